// File: core/iuvfr_pkg.sv
// Purpose: Constants and types for the input undervoltage fault response block
// Assumes: 250 MHz mclk, command codes decoded by the device command port
// Notes:   Shared by the controller, its interval timer and their interface
//
// Contract
// - Fault when measured input below low threshold
// - Action 00 ignores fault, output keeps running
// - Action 01 keeps running for programmed delay
// - Action 01 fault persisting at expiry follows retries
// - Action 10 disables output, then follows retries
// - Action 11 disables output until fault cleared
// - Clear by bit clear, clear command, reset, off-on
// - Retry 000 never restarts, output stays off
// - Retry 001 to 110 gives that many attempts
// - All attempts failed: output held off until cleared
// - Attempt starts spaced by programmed interval
// - Retry 111 retries until off or shutdown
// - Interval field n means two to n units
// - Time unit length comes from separate register
// - Action byte readable and writable as byte
`default_nettype none

package iuvfr_pkg;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_LOW_THRESH   = 8'h59;
	localparam logic [7:0] CMD_FAULT_ACTION = 8'h5A;
	localparam logic [7:0] CMD_TIME_UNIT    = 8'hD2;

	// ----------------------------------------------------------------
	// Field layout of the action byte
	// ----------------------------------------------------------------
	localparam int ACT_MODE_HI  = 7;
	localparam int ACT_MODE_LO  = 6;
	localparam int ACT_RETRY_HI = 5;
	localparam int ACT_RETRY_LO = 3;
	localparam int ACT_TIME_HI  = 2;
	localparam int ACT_TIME_LO  = 0;

	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_DELAY  = 2'h1;
	localparam logic [1:0] MODE_RETRY  = 2'h2;
	localparam logic [1:0] MODE_LATCH  = 2'h3;

	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ACTION_RESET = 8'h80;
	localparam logic [15:0] THRESH_RESET = 16'h0000;
	localparam logic [15:0] UNIT_RESET   = 16'h0000;

	// ----------------------------------------------------------------
	// Timing: one time unit is (unit register + 1) base ticks
	// ----------------------------------------------------------------
	localparam int CLK_MHZ         = 250;
	localparam int BASE_TICK_NS    = 1000;
	localparam int BASE_TICK_CYC   = (BASE_TICK_NS * CLK_MHZ) / 1000;
	localparam logic [7:0] TICK_LAST = 8'(BASE_TICK_CYC - 1);

	typedef logic [15:0] iuvfr_word_t;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_DELAY = 2'b01,
		ST_WAIT  = 2'b10,
		ST_LATCH = 2'b11
	} iuvfr_state_e;

endpackage

`default_nettype wire

// File: core/iuvfr_tmr_if.sv
// Purpose: Carrier between the fault controller and its interval timer
// Assumes: Single mclk domain
// Notes:   Start is a one-cycle pulse, cancel stays high while its cause holds (e.g. commanded off), expired is one cycle
`timescale 1ns/1ps
`default_nettype none

interface iuvfr_tmr_if;
	import iuvfr_pkg::*;
	logic        start;
	logic        cancel;
	logic [2:0]  shift;
	iuvfr_word_t unit;
	logic        expired;

	modport ctl (output start, output cancel, output shift, output unit, input expired);
	modport tmr (input start, input cancel, input shift, input unit, output expired);
endinterface

`default_nettype wire

// File: core/iuvfr_timer.sv
// Purpose: Interval timer counting 2^n time units
// Assumes: Unit length set by the time unit register
// Notes:   Expired pulses once, one cycle after the last tick
`timescale 1ns/1ps
`default_nettype none

module iuvfr_timer
	import iuvfr_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_b,
	iuvfr_tmr_if.tmr  t
);
	import iuvfr_pkg::*;

	typedef struct packed {
		logic        run;
		logic [7:0]  tick;
		iuvfr_word_t ucnt;
		logic [7:0]  ncnt;
		logic        exp;
	} iuvfr_tmr_s;

	iuvfr_tmr_s tmr_reg;
	iuvfr_tmr_s tmr_next;
	logic [7:0] units_last;

	// -----------------------------------------------------------------
	// Counting
	// -----------------------------------------------------------------
	always_comb begin
		tmr_next = tmr_reg;
		tmr_next.exp = 1'b0;
		units_last = 8'((9'h001 << t.shift) - 9'h001);
		if (t.cancel) begin
			tmr_next.run = 1'b0;
		end else if (t.start) begin
			tmr_next.run = 1'b1;
			tmr_next.tick = 8'h00;
			tmr_next.ucnt = 16'h0000;
			tmr_next.ncnt = 8'h00;
		end else if (tmr_reg.run) begin
			if (tmr_reg.tick != TICK_LAST) begin
				tmr_next.tick = tmr_reg.tick + 8'h01;
			end else begin
				tmr_next.tick = 8'h00;
				if (tmr_reg.ucnt != t.unit) begin
					tmr_next.ucnt = tmr_reg.ucnt + 16'h0001;
				end else begin
					tmr_next.ucnt = 16'h0000;
					if (tmr_reg.ncnt != units_last) begin
						tmr_next.ncnt = tmr_reg.ncnt + 8'h01;
					end else begin
						tmr_next.run = 1'b0;
						tmr_next.exp = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tmr_reg <= '0;
		end else begin
			tmr_reg <= tmr_next;
		end
	end

	assign t.expired = tmr_reg.exp;

endmodule

`default_nettype wire

// File: core/iuvfr_top.sv
// Purpose: Input undervoltage fault response controller
// Assumes: Command port is already decoded from the management bus
// Notes:   Output enable and all outputs come straight from flops
`timescale 1ns/1ps
`default_nettype none

module iuvfr_top
	import iuvfr_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         cmd_valid,
	input  wire logic         cmd_write,
	input  wire logic [7:0]   cmd_code,
	input  wire iuvfr_word_t  cmd_wdata,
	input  wire iuvfr_word_t  vin_meas,
	input  wire logic         run_cmd,
	input  wire logic         fault_bit_clr,
	input  wire logic         ext_shutdown,
	output logic              out_enable,
	output logic              fault_latched,
	output logic              fault_active,
	output iuvfr_word_t       rsp_data,
	output logic              rsp_valid,
	output logic              rsp_err
);
	import iuvfr_pkg::*;

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		iuvfr_state_e st;
		logic         out_en;
		logic         latched;
		logic         flt;
		logic [2:0]   tries;
		logic         run_d;
		logic [7:0]   action;
		iuvfr_word_t  thresh;
		iuvfr_word_t  unit;
		iuvfr_word_t  rdata;
		logic         rvalid;
		logic         rerr;
		logic         tstart;
		logic         tcancel;
	} iuvfr_ctl_s;

	iuvfr_ctl_s   ctl_reg;
	iuvfr_ctl_s   ctl_next;
	iuvfr_tmr_if  tif ();

	logic         uv_fault;
	logic         clear_evt;
	logic         trip;
	logic [1:0]   mode;
	logic [2:0]   retry;

	// Retries exhausted once the failing attempt reaches the setting
	function automatic logic out_of_tries(input logic [2:0] done, input logic [2:0] setting);
		logic [3:0] used;
		used = {1'b0, done} + 4'h1;
		out_of_tries = (setting != RETRY_FOREVER) && (used >= {1'b0, setting});
	endfunction

	assign mode  = ctl_reg.action[ACT_MODE_HI:ACT_MODE_LO];
	assign retry = ctl_reg.action[ACT_RETRY_HI:ACT_RETRY_LO];

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		ctl_next = ctl_reg;
		ctl_next.rvalid = 1'b0;
		ctl_next.rerr = 1'b0;
		ctl_next.tstart = 1'b0;
		ctl_next.tcancel = 1'b0;
		ctl_next.run_d = run_cmd;
		trip = 1'b0;
		clear_evt = fault_bit_clr;

		// Raw unsigned compare: both words share one encoding
		uv_fault = (vin_meas < ctl_reg.thresh);
		ctl_next.flt = uv_fault;

		if (cmd_valid) begin
			if (cmd_write) begin
				if (cmd_code == CMD_FAULT_ACTION) begin
					ctl_next.action = cmd_wdata[7:0];
				end else if (cmd_code == CMD_LOW_THRESH) begin
					ctl_next.thresh = cmd_wdata;
				end else if (cmd_code == CMD_TIME_UNIT) begin
					ctl_next.unit = cmd_wdata;
				end else if (cmd_code == CMD_CLEAR_FAULTS) begin
					clear_evt = 1'b1;
				end else begin
					ctl_next.rerr = 1'b1;
				end
			end else begin
				ctl_next.rvalid = 1'b1;
				if (cmd_code == CMD_FAULT_ACTION) begin
					ctl_next.rdata = {8'h00, ctl_reg.action};
				end else if (cmd_code == CMD_LOW_THRESH) begin
					ctl_next.rdata = ctl_reg.thresh;
				end else if (cmd_code == CMD_TIME_UNIT) begin
					ctl_next.rdata = ctl_reg.unit;
				end else begin
					ctl_next.rdata = 16'h0000;
					ctl_next.rerr = 1'b1;
				end
			end
		end

		// Off-then-on of the run command clears a latched fault
		if (run_cmd && !ctl_reg.run_d) begin
			clear_evt = 1'b1;
		end

		if (!run_cmd) begin
			// Commanded off: nothing pending survives
			ctl_next.st = ST_RUN;
			ctl_next.out_en = 1'b0;
			ctl_next.tries = 3'h0;
			ctl_next.tcancel = 1'b1;
		end else if (ext_shutdown) begin
			ctl_next.st = ST_LATCH;
			ctl_next.out_en = 1'b0;
			ctl_next.tcancel = 1'b1;
		end else if (clear_evt) begin
			ctl_next.st = ST_RUN;
			ctl_next.out_en = 1'b1;
			ctl_next.tries = 3'h0;
			ctl_next.tcancel = 1'b1;
			// Set wins: a fault still present in latch or retry mode re-arms at once, no output glitch
			if (uv_fault && (mode == MODE_LATCH)) begin
				ctl_next.st = ST_LATCH;
				ctl_next.out_en = 1'b0;
			end else if (uv_fault && (mode == MODE_RETRY)) begin
				trip = 1'b1;
			end
		end else begin
			case (ctl_reg.st)
				ST_RUN: begin
					ctl_next.out_en = 1'b1;
					if (uv_fault) begin
						case (mode)
							MODE_IGNORE: begin
								ctl_next.out_en = 1'b1;
							end
							MODE_DELAY: begin
								ctl_next.st = ST_DELAY;
								ctl_next.tstart = 1'b1;
							end
							MODE_RETRY: begin
								trip = 1'b1;
							end
							default: begin
								ctl_next.st = ST_LATCH;
								ctl_next.out_en = 1'b0;
							end
						endcase
					end
				end
				ST_DELAY: begin
					ctl_next.out_en = 1'b1;
					if (!uv_fault) begin
						ctl_next.st = ST_RUN;
						ctl_next.tcancel = 1'b1;
					end else if (tif.expired) begin
						trip = 1'b1;
					end
				end
				ST_WAIT: begin
					ctl_next.out_en = 1'b0;
					if (tif.expired) begin
						if (!uv_fault) begin
							// Restart attempt succeeds
							ctl_next.st = ST_RUN;
							ctl_next.out_en = 1'b1;
							ctl_next.tries = 3'h0;
						end else if (out_of_tries(ctl_reg.tries, retry)) begin
							ctl_next.st = ST_LATCH;
						end else begin
							if (retry != RETRY_FOREVER) begin
								ctl_next.tries = ctl_reg.tries + 3'h1;
							end
							ctl_next.tstart = 1'b1;
						end
					end
				end
				default: begin
					ctl_next.out_en = 1'b0;
				end
			endcase
		end

		// Shutdown path shared by disable-and-retry and expired delay
		if (trip) begin
			ctl_next.out_en = 1'b0;
			// Cancel would swallow the start in the timer
			ctl_next.tcancel = 1'b0;
			if (retry == RETRY_NONE) begin
				ctl_next.st = ST_LATCH;
			end else begin
				ctl_next.st = ST_WAIT;
				ctl_next.tstart = 1'b1;
			end
		end

		ctl_next.latched = (ctl_next.st == ST_LATCH);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_reg <= '0;
			ctl_reg.action <= ACTION_RESET;
			ctl_reg.thresh <= THRESH_RESET;
			ctl_reg.unit <= UNIT_RESET;
			ctl_reg.st <= ST_RUN;
		end else begin
			ctl_reg <= ctl_next;
		end
	end

	// -----------------------------------------------------------------
	// Interval timer
	// -----------------------------------------------------------------
	assign tif.start  = ctl_reg.tstart;
	assign tif.cancel = ctl_reg.tcancel;
	assign tif.shift  = ctl_reg.action[ACT_TIME_HI:ACT_TIME_LO];
	assign tif.unit   = ctl_reg.unit;

	iuvfr_timer u_timer (
		.mclk  (mclk),
		.rst_b (rst_b),
		.t     (tif.tmr)
	);

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign out_enable    = ctl_reg.out_en;
	assign fault_latched = ctl_reg.latched;
	assign fault_active  = ctl_reg.flt;
	assign rsp_data      = ctl_reg.rdata;
	assign rsp_valid     = ctl_reg.rvalid;
	assign rsp_err       = ctl_reg.rerr;

endmodule

`default_nettype wire

// File: test/iuvfr_chk.sv
// Purpose: Assertions on the fault response top ports
// Assumes: One mclk domain
// Notes:   Keeps its own copy of the action byte
`timescale 1ns/1ps
`default_nettype none
module iuvfr_chk
	import iuvfr_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [7:0]  cmd_code,
	input wire iuvfr_word_t cmd_wdata,
	input wire logic        run_cmd,
	input wire logic        fault_bit_clr,
	input wire logic        ext_shutdown,
	input wire iuvfr_word_t vin_meas,
	input wire logic        out_enable,
	input wire logic        fault_latched,
	input wire logic        fault_active,
	input wire iuvfr_word_t rsp_data,
	input wire logic        rsp_valid
);
	logic [7:0]  act_reg;
	iuvfr_word_t thr_reg;
	logic        clr;
	logic        flt_now;
	assign clr = fault_bit_clr || (cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS);
	assign flt_now = (vin_meas < thr_reg);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			act_reg <= ACTION_RESET;
		else if (cmd_valid && cmd_write && cmd_code == CMD_FAULT_ACTION)
			act_reg <= cmd_wdata[7:0];
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			thr_reg <= THRESH_RESET;
		else if (cmd_valid && cmd_write && cmd_code == CMD_LOW_THRESH)
			thr_reg <= cmd_wdata;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence rd_act;
		cmd_valid && !cmd_write && cmd_code == CMD_FAULT_ACTION;
	endsequence
	sequence rd_ans;
		rsp_valid && rsp_data == {8'h00, act_reg};
	endsequence
	read_back_a: assert property (rd_act |=> rd_ans)
		else $error("action byte read wrong");
	no_rsp_a: assert property (!cmd_valid |=> !rsp_valid)
		else $error("answer without command");
	off_cmd_a: assert property (!run_cmd |=> !out_enable)
		else $error("output on while commanded off");
	latch_off_a: assert property (fault_latched |-> !out_enable)
		else $error("output on while latched");
	ignore_on_a: assert property (act_reg[7:6] == MODE_IGNORE && run_cmd && !ext_shutdown
		&& !fault_latched && !cmd_valid |=> out_enable)
		else $error("ignore mode dropped output");
	fast_off_a: assert property (act_reg[7] && run_cmd && $past(run_cmd) && !cmd_valid
		&& !fault_bit_clr |=> (fault_active |-> !out_enable))
		else $error("output kept on at fault");
	latch_keep_a: assert property (fault_latched && run_cmd && $past(run_cmd) && !clr
		|=> fault_latched)
		else $error("latch lost without clear");
	clr_works_a: assert property (fault_latched && clr && !ext_shutdown && !flt_now
		|=> !fault_latched)
		else $error("clear ignored");
	off_on_a: assert property ($rose(run_cmd) && !ext_shutdown && !flt_now
		|=> !fault_latched)
		else $error("off-on did not clear");
	set_wins_a: assert property (clr && run_cmd && !ext_shutdown && flt_now
		&& act_reg[7:6] == MODE_LATCH |=> fault_latched && !out_enable)
		else $error("clear let a present fault through");
endmodule
bind iuvfr_top iuvfr_chk u_chk (.mclk, .rst_b, .cmd_valid, .cmd_write, .cmd_code,
	.cmd_wdata, .run_cmd, .fault_bit_clr, .ext_shutdown, .vin_meas, .out_enable, .fault_latched,
	.fault_active, .rsp_data, .rsp_valid);
`default_nettype wire

// File: test/iuvfr_host.sv
// Purpose: Host side of the command port
// Assumes: One command per call, idle cycle between
// Notes:   Write data is inverted once released
`timescale 1ns/1ps
`default_nettype none
module iuvfr_host
	import iuvfr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rsp_valid,
	input  wire logic        rsp_err,
	input  wire iuvfr_word_t rsp_data,
	output logic             cmd_valid,
	output logic             cmd_write,
	output logic [7:0]       cmd_code,
	output iuvfr_word_t      cmd_wdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	task automatic xfer(input logic w, input logic [7:0] c, input iuvfr_word_t d,
		output iuvfr_word_t q, output logic e);
		@(posedge mclk) #1;
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_wdata = d;
		@(posedge mclk) #1;
		q = rsp_valid ? rsp_data : 16'hDEAD;
		e = rsp_err;
		cmd_valid = 1'b0;
		cmd_wdata = ~d;
	endtask
endmodule
`default_nettype wire

// File: test/iuvfr_top_tb.sv
// Purpose: Self-checking bench for the fault response top
// Assumes: Unit register 0 outside the time unit test, so one time unit is 250 cycles
// Notes:   Rows cover register access, hand tests the fault paths
`timescale 1ns/1ps
`default_nettype none
module iuvfr_top_tb;
	import iuvfr_pkg::*;
	typedef struct packed {
		logic        w;
		logic [7:0]  c;
		logic [15:0] d;
		logic [15:0] q;
		logic        e;
	} iuvfr_row_s;
	logic        mclk = 1'b0, rst_b = 1'b0, run_cmd = 1'b1;
	logic        fault_bit_clr = 1'b0, ext_shutdown = 1'b0;
	logic        cmd_valid, cmd_write, rsp_valid, rsp_err, e;
	logic        out_enable, fault_latched, fault_active;
	logic [7:0]  cmd_code;
	iuvfr_word_t cmd_wdata, rsp_data, q;
	iuvfr_word_t vin_meas = 16'h0200;
	int          errors = 0, samples_checked = 0, cyc = 0, t, r;
	iuvfr_row_s  rows [10];
	logic [5:0]  rt [4] = '{6'h00, 6'h08, 6'h10, 6'h0A};
	iuvfr_host host (.mclk, .rsp_valid, .rsp_err, .rsp_data, .cmd_valid, .cmd_write,
		.cmd_code, .cmd_wdata);
	iuvfr_top dut (.mclk, .rst_b, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .vin_meas,
		.run_cmd, .fault_bit_clr, .ext_shutdown, .out_enable, .fault_latched,
		.fault_active, .rsp_data, .rsp_valid, .rsp_err);
	always #2 mclk = ~mclk;
	task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
		samples_checked++;
		if (g !== x) begin
			$display("[ERR] %s expected %h seen %h", n, x, g);
			errors++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic put(input logic [7:0] c, input iuvfr_word_t d);
		host.xfer(1'b1, c, d, q, e);
	endtask
	task automatic clear();
		vin_meas = 16'h0200;
		fault_bit_clr = 1'b1;
		tick(1);
		fault_bit_clr = 1'b0;
		tick(2);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Ceiling well above the roughly 5000 cycles the tests need
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		rows = '{'{1'b0, 8'h5A, 16'h0000, 16'h0080, 1'b0}, '{1'b1, 8'h5A, 16'h00C5, 16'h0, 1'b0},
			'{1'b0, 8'h5A, 16'h0000, 16'h00C5, 1'b0}, '{1'b1, 8'h59, 16'h0100, 16'h0, 1'b0},
			'{1'b0, 8'h59, 16'h0000, 16'h0100, 1'b0}, '{1'b0, 8'hD2, 16'h0000, 16'h0000, 1'b0},
			'{1'b1, 8'hD2, 16'h0000, 16'h0, 1'b0}, '{1'b0, 8'h03, 16'h0000, 16'h0, 1'b1},
			'{1'b0, 8'h77, 16'h0000, 16'h0, 1'b1}, '{1'b1, 8'h77, 16'h0000, 16'h0, 1'b1}};
		tick(6);
		rst_b = 1'b1;
		tick(2);
		chk("out_enable", 1, out_enable);
		foreach (rows[i]) begin
			host.xfer(rows[i].w, rows[i].c, rows[i].d, q, e);
			chk("rsp_err", rows[i].e, e);
			if (!rows[i].w && !rows[i].e) chk("rsp_data", rows[i].q, q);
		end
		$display("register rows done");
		put(CMD_FAULT_ACTION, 16'h00C0);
		vin_meas = 16'h0080;
		tick(3);
		chk("fault_active", 1, fault_active);
		chk("out_enable", 0, out_enable);
		fault_bit_clr = 1'b1;
		tick(1);
		fault_bit_clr = 1'b0;
		tick(1);
		chk("fault_latched", 1, fault_latched);
		chk("out_enable", 0, out_enable);
		vin_meas = 16'h0200;
		tick(5);
		chk("fault_latched", 1, fault_latched);
		put(CMD_CLEAR_FAULTS, 16'h0000);
		tick(2);
		chk("out_enable", 1, out_enable);
		$display("latch mode done");
		put(CMD_FAULT_ACTION, 16'h0000);
		vin_meas = 16'h0080;
		tick(20);
		chk("out_enable", 1, out_enable);
		vin_meas = 16'h0200;
		tick(2);
		put(CMD_FAULT_ACTION, 16'h0040);
		vin_meas = 16'h0080;
		tick(100);
		chk("out_enable", 1, out_enable);
		vin_meas = 16'h0200;
		tick(300);
		chk("out_enable", 1, out_enable);
		vin_meas = 16'h0080;
		tick(240);
		chk("out_enable", 1, out_enable);
		tick(30);
		chk("fault_latched", 1, fault_latched);
		clear();
		$display("ignore and delay modes done");
		foreach (rt[i]) begin
			put(CMD_FAULT_ACTION, {8'h00, 2'b10, rt[i]});
			vin_meas = 16'h0080;
			r = int'(rt[i][5:3]);
			t = r * (250 << rt[i][2:0]);
			tick(5);
			chk("out_enable", 0, out_enable);
			if (t > 0) begin
				tick(t - 10);
				chk("fault_latched", 0, fault_latched);
			end
			tick(15 + 10 * r);
			chk("fault_latched", 1, fault_latched);
			clear();
			chk("out_enable", 1, out_enable);
		end
		$display("retry counts done");
		put(CMD_TIME_UNIT, 16'h0001);
		put(CMD_FAULT_ACTION, 16'h0088);
		vin_meas = 16'h0080;
		tick(490);
		chk("fault_latched", 0, fault_latched);
		tick(25);
		chk("fault_latched", 1, fault_latched);
		clear();
		put(CMD_TIME_UNIT, 16'h0000);
		$display("time unit done");
		put(CMD_FAULT_ACTION, 16'h00B8);
		vin_meas = 16'h0080;
		tick(1500);
		chk("fault_latched", 0, fault_latched);
		vin_meas = 16'h0200;
		tick(270);
		chk("out_enable", 1, out_enable);
		run_cmd = 1'b0;
		tick(2);
		chk("out_enable", 0, out_enable);
		run_cmd = 1'b1;
		ext_shutdown = 1'b1;
		tick(1);
		ext_shutdown = 1'b0;
		tick(2);
		chk("fault_latched", 1, fault_latched);
		run_cmd = 1'b0;
		tick(2);
		run_cmd = 1'b1;
		tick(3);
		chk("fault_latched", 0, fault_latched);
		$display("endless retry done");
		put(CMD_FAULT_ACTION, 16'h00C0);
		vin_meas = 16'h0080;
		tick(3);
		chk("fault_latched", 1, fault_latched);
		rst_b = 1'b0;
		vin_meas = 16'h0200;
		tick(2);
		chk("fault_latched", 0, fault_latched);
		chk("out_enable", 0, out_enable);
		rst_b = 1'b1;
		tick(2);
		chk("out_enable", 1, out_enable);
		host.xfer(1'b0, CMD_FAULT_ACTION, 16'h0000, q, e);
		chk("rsp_data", 16'h0080, q);
		$display("mid-run reset done");
		close_out();
	end
endmodule
`default_nettype wire
